/* File: testbench/rsw_monitor.sv */
// Purpose: Assertions on the link between core end and device end
// Assumes: One pclk domain, presetn asynchronous and active low
// Notes:   Fuses are not visible here; the bench checks them at the pins
module rsw_monitor
    import rsw_pkg::*;
(
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       ctl_wr,
    input wire logic       cause_wr,
    input wire logic [7:0] wr_data,
    input wire logic       wd_restart,
    input wire logic       irq_ack,
    input wire logic [7:0] ctl_rd,
    input wire logic [3:0] cause_rd,
    input wire logic       wd_irq,
    input wire logic       core_reset
);
    timeunit 1ns;
    timeprecision 1ns;

    // All checks share the system clock
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_chg_self_clear: assert property ($rose(ctl_rd[CTL_CHG_EN]) |-> ##[1:5]
        !ctl_rd[CTL_CHG_EN]) else $error("change enable did not close");
    chk_open_sets: assert property (ctl_wr && wr_data[CTL_CHG_EN] && wr_data[CTL_RST_EN]
        && !core_reset |=> ctl_rd[CTL_CHG_EN] && ctl_rd[CTL_RST_EN])
        else $error("opening write not honoured");
    chk_win_write: assert property (ctl_wr && !wr_data[CTL_CHG_EN] && ctl_rd[CTL_CHG_EN]
        && !core_reset |=> !ctl_rd[CTL_CHG_EN] && ctl_rd[2:0] == $past(wr_data[2:0]))
        else $error("write in open window not taken");
    // Closed window may only raise reset enable, never move the prescaler
    chk_closed_keep: assert property (ctl_wr && !wr_data[CTL_CHG_EN] && !ctl_rd[CTL_CHG_EN]
        && !core_reset |=> $stable(ctl_rd[2:0]) && $stable(ctl_rd[CTL_PRESC3])
        && ctl_rd[CTL_RST_EN] >= $past(ctl_rd[CTL_RST_EN]))
        else $error("protected bits changed outside window");
    chk_flag_forces: assert property (cause_rd[CAUSE_WD] && $past(cause_rd[CAUSE_WD])
        |-> ctl_rd[CTL_RST_EN]) else $error("reset enable not forced by flag");
    chk_ack_drops_ie: assert property (irq_ack && !ctl_wr && ctl_rd[CTL_RST_EN]
        |=> !ctl_rd[CTL_IRQ_EN]) else $error("ack kept irq enable in combined mode");
    chk_restart_quiet: assert property (wd_restart |=> (!$rose(wd_irq)) [*8])
        else $error("expiry right after restart");
    chk_wd_stretch: assert property ($rose(cause_rd[CAUSE_WD]) |-> core_reset [*8])
        else $error("watchdog reset not stretched");

    cover property (ctl_wr && ctl_rd[CTL_CHG_EN]);
    cover property ($rose(wd_irq));
    cover property ($rose(cause_rd[CAUSE_WD]));
endmodule

/* File: testbench/test_reset_sources_and_watchdog.sv */
// Purpose: Self-checking bench for core end and device end back to back
// Assumes: Short start-up stretch, fast watchdog oscillator (period 4 pclk)
// Notes:   Reads note expectations in a queue; a watcher compares them
module test_reset_sources_and_watchdog
    import rsw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SU = 16; // Shortened stretch keeps the run brief
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, core_reset, bandgap_on;
    logic        ext_reset_n = 1'b1, por_low = 1'b1, drop_low = 1'b0;
    logic [2:0]  drop_level_fuses = DROP_FUSE_OFF;
    logic        pin_fuse = 1'b0, aon_fuse = 1'b0, cmp_bg = 1'b0, adc_en = 1'b0;
    logic        wd_osc = 1'b0;
    logic [1:0]  osc_div = 2'h0;
    logic [32:0] exp_q[$], mask_q[$];
    int          fails = 0, n_compared = 0, n;

    always #10 pclk = ~pclk;

    // Slow oscillator runs free, unrelated to APB traffic
    always @(posedge pclk) begin
        osc_div <= osc_div + 2'h1;
        if (osc_div[0])
            wd_osc <= ~wd_osc;
    end

    rsw_link_if link_i ();
    rsw_core_end rsw_core_end_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link_i));
    rsw_device_end #(.STARTUP_CNT(SU)) rsw_device_end_i (.pclk(pclk), .presetn(presetn),
        .link(link_i), .ext_reset_n(ext_reset_n), .por_low(por_low), .drop_low(drop_low),
        .drop_level_fuses(drop_level_fuses), .ext_pin_reset_disable_fuse(pin_fuse),
        .watchdog_always_on_fuse(aon_fuse), .comparator_bandgap_select(cmp_bg),
        .adc_enable(adc_en), .wd_osc(wd_osc), .core_reset(core_reset),
        .bandgap_on(bandgap_on));
    rsw_monitor rsw_monitor_i (.pclk(pclk), .presetn(presetn), .ctl_wr(link_i.ctl_wr),
        .cause_wr(link_i.cause_wr), .wr_data(link_i.wr_data),
        .wd_restart(link_i.wd_restart), .irq_ack(link_i.irq_ack), .ctl_rd(link_i.ctl_rd),
        .cause_rd(link_i.cause_rd), .wd_irq(link_i.wd_irq), .core_reset(link_i.core_reset));

    task check(input logic [32:0] seen, input logic [32:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task ok(input logic c);
        check({32'h0, c}, 33'h1);
    endtask

    task conclude();
        // A read that never completed would otherwise go unnoticed
        if (exp_q.size() != 0) begin
            fails++;
            $display("mismatch at %0t: reads left unchecked", $time);
        end
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // One APB transfer; request held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    // Extra idle edge lets a link update land before prdata is captured
    task rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
        exp_q.push_back(e & m);
        mask_q.push_back(m);
        @(posedge pclk);
        apb(1'b0, a, 32'h0);
    endtask

    task wait_for(input bit irq, input logic lvl, input int lim);
        n = 0;
        while (((irq ? link_i.wd_irq : core_reset) !== lvl) && n < lim) begin
            @(posedge pclk);
            n++;
        end
        // A wait that runs out is a failure, not a long count
        if (n >= lim) begin
            fails++;
            $display("mismatch at %0t: wait timed out", $time);
        end
    endtask

    // Read watcher: compares each completed read with the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
            check({pslverr, prdata} & mask_q[0], exp_q[0]);
            void'(exp_q.pop_front());
            void'(mask_q.pop_front());
        end
    end

    // Watchdog against a hang; the tests need about 31k cycles
    initial begin
        repeat (60000) @(posedge pclk);
        fails++;
        conclude();
    end

    initial begin
        void'($urandom(63));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        por_low <= 1'b0;
        wait_for(0, 1'b0, 200);
        ok(n >= SU);
        @(posedge pclk);
        ext_reset_n <= 1'b0;
        #5 ok(core_reset === 1'b1);
        repeat (10) @(posedge pclk);
        ext_reset_n <= 1'b1;
        wait_for(0, 1'b0, 200);
        ok(n >= SU);
        pin_fuse <= 1'b1;
        repeat (4) @(posedge pclk);
        ext_reset_n <= 1'b0;
        repeat (8) @(posedge pclk);
        ok(core_reset === 1'b0);
        ext_reset_n <= 1'b1;
        pin_fuse <= 1'b0;
        por_low <= 1'b1;
        #5 ok(core_reset === 1'b1);
        repeat (4) @(posedge pclk);
        por_low <= 1'b0;
        wait_for(0, 1'b0, 200);
        ok(n >= SU);
        drop_level_fuses <= 3'($urandom_range(6, 0));
        repeat (4) @(posedge pclk);
        drop_low <= 1'b1;
        #5 ok(core_reset === 1'b1);
        repeat (6) @(posedge pclk);
        drop_low <= 1'b0;
        wait_for(0, 1'b0, 200);
        ok(n >= SU);
        ok(bandgap_on === 1'b1);
        drop_level_fuses <= DROP_FUSE_OFF;
        for (int i = 0; i < 4; i++) begin
            @(posedge pclk);
            {cmp_bg, adc_en} <= 2'(i);
            repeat (4) @(posedge pclk);
            ok(bandgap_on === (i != 0));
        end
        rd(8'h10, {1'b1, 32'h0}, {33{1'b1}});
        wr(OFS_CONTROL, 32'h08);
        wr(OFS_CONTROL, 32'h00);
        rd(OFS_CONTROL, 33'h08, 33'hFF);
        wr(OFS_CONTROL, 32'h18);
        wr(OFS_CONTROL, 32'h05);
        rd(OFS_CONTROL, 33'h05, 33'hFF);
        wr(OFS_CONTROL, 32'h18);
        rd(OFS_CONTROL, 33'h18, 33'h18);
        repeat (8) @(posedge pclk);
        rd(OFS_CONTROL, 33'h00, 33'h10);
        wr(OFS_CONTROL, 32'h00);
        rd(OFS_CONTROL, 33'h0D, 33'h0F);
        wr(OFS_COMMAND, 32'h1);
        wr(OFS_COMMAND, 32'h4);
        wr(OFS_CONTROL, 32'h40);
        rd(OFS_CONTROL, 33'h40, 33'hFF);
        wr(OFS_COMMAND, 32'h1);
        repeat (6000) @(posedge pclk);
        ok(link_i.wd_irq === 1'b0);
        wr(OFS_COMMAND, 32'h1);
        wait_for(1, 1'b1, 9000);
        ok(n > 8170 && n < 8215);
        rd(OFS_STATUS, 33'h1, 33'h1);
        wr(OFS_COMMAND, 32'h2);
        rd(OFS_CONTROL, 33'h40, 33'hC0);
        wr(OFS_COMMAND, 32'h4);
        wr(OFS_CONTROL, 32'h48);
        wr(OFS_COMMAND, 32'h1);
        wait_for(1, 1'b1, 9000);
        ok(n < 8300);
        wr(OFS_COMMAND, 32'h2);
        rd(OFS_CONTROL, 33'h08, 33'hC8);
        wait_for(0, 1'b1, 9000);
        ok(n < 8300);
        wait_for(0, 1'b0, 200);
        ok(n >= SU);
        rd(OFS_CAUSE, 33'h8, 33'h8);
        rd(OFS_CONTROL, 33'h08, 33'h08);
        wr(OFS_COMMAND, 32'h1);
        wr(OFS_CAUSE, 32'h0);
        wr(OFS_COMMAND, 32'h4);
        wr(OFS_CONTROL, 32'h00);
        rd(OFS_CONTROL, 33'h00, 33'hFF);
        aon_fuse <= 1'b1;
        repeat (4) @(posedge pclk);
        wr(OFS_CONTROL, 32'h40);
        rd(OFS_CONTROL, 33'h08, 33'h48);
        repeat (4) @(posedge pclk);
        conclude();
    end
endmodule

/* File: verilog/rsw_core_end.sv */
// Purpose: APB front end that drives the watchdog link for software
// Assumes: Zero wait state APB slave on pclk
// Notes:   One-cycle link strobes follow the access edge by one cycle
module rsw_core_end
    import rsw_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [APB_AW-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    rsw_link_if.core               link
);
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        ctl_wr;
        logic        cause_wr;
        logic [7:0]  wr_data;
        logic        restart;
        logic        ack;
    } rsw_core_state_t;

    rsw_core_state_t q;
    rsw_core_state_t d;

    // Decode in setup, act on the access edge
    always_comb begin
        logic hit;
        logic done;
        d          = q;
        hit        = (paddr == OFS_CONTROL) || (paddr == OFS_CAUSE)
                   || (paddr == OFS_COMMAND) || (paddr == OFS_STATUS);
        done       = psel & penable & q.pready;
        d.ctl_wr   = 1'b0;
        d.cause_wr = 1'b0;
        d.restart  = 1'b0;
        d.ack      = 1'b0;
        d.pready   = psel & ~penable;
        d.pslverr  = 1'b0;
        if (psel && !penable) begin
            d.pslverr = ~hit;
            d.prdata  = '0;
            case (paddr)
                OFS_CONTROL: d.prdata[7:0] = link.ctl_rd;
                OFS_CAUSE:   d.prdata[3:0] = link.cause_rd;
                OFS_STATUS:  d.prdata[1:0] = {link.core_reset, link.wd_irq};
                default:     d.prdata      = '0;
            endcase
        end
        if (done && pwrite) begin
            d.wr_data = pwdata[7:0];
            case (paddr)
                OFS_CONTROL: d.ctl_wr = 1'b1;
                OFS_CAUSE:   d.cause_wr = 1'b1;
                OFS_COMMAND: begin
                    d.restart = pwdata[CMD_RESTART];
                    d.ack     = pwdata[CMD_IRQ_ACK];
                    // Opening write keeps settings but never clears the flag
                    if (pwdata[CMD_OPEN_CHANGE]) begin
                        d.ctl_wr  = 1'b1;
                        d.wr_data = (link.ctl_rd & 8'h7F)
                                  | (8'h01 << CTL_CHG_EN) | (8'h01 << CTL_RST_EN);
                    end
                end
                default: d.wr_data = q.wr_data;
            endcase
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign prdata          = q.prdata;
    assign pready          = q.pready;
    assign pslverr         = q.pslverr;
    assign link.ctl_wr     = q.ctl_wr;
    assign link.cause_wr   = q.cause_wr;
    assign link.wr_data    = q.wr_data;
    assign link.wd_restart = q.restart;
    assign link.irq_ack    = q.ack;
endmodule

/* File: verilog/rsw_device_end.sv */
// Purpose: Reset source merger, start-up stretch and watchdog timer
// Assumes: Source pins and oscillator arrive asynchronously to pclk
// Notes:   Asserting a reset source needs no clock; release is clocked
//
// Implementation choices: the address map and the APB slave port.

// Contract
// - Long low on reset pin resets without clock
// - Pin release waits start-up delay
// - Fuse can disable the reset pin
// - Supply drop resets at once, delayed release
// - Power-on starts delay, low supply resets again
// - Watchdog reset pulse is one clock long
// - Watchdog counts its own slow oscillator
// - Restart clears counter; missing restart expires
// - Interrupt mode expiry requests interrupt, wakes
// - Reset mode expiry resets the system
// - Combined mode: interrupt first, then reset
// - Always-on fuse forces reset mode bits
// - Opening write sets change and reset enable
// - New settings written within four cycles
// - Watchdog keeps counting during sleep
// - Time-out selectable from shortest to longest
// - Restart before shortening the prescaler
// - Init code clears watchdog flag and enable
// - Bandgap on for detector, comparator or converter
// - Watchdog reset flag forces reset enable
// - Prescaler codes pick power-of-two periods
// - Change enable self-clears after four cycles
// - Vector clears flag, combined drops irq enable
module rsw_device_end
    import rsw_pkg::*;
#(
    parameter int STARTUP_CNT = STARTUP_CYCLES
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    rsw_link_if.dev         link,
    input  wire logic       ext_reset_n,
    input  wire logic       por_low,
    input  wire logic       drop_low,
    input  wire logic [2:0] drop_level_fuses,
    input  wire logic       ext_pin_reset_disable_fuse,
    input  wire logic       watchdog_always_on_fuse,
    input  wire logic       comparator_bandgap_select,
    input  wire logic       adc_enable,
    input  wire logic       wd_osc,
    output logic            core_reset,
    output logic            bandgap_on
);
    // Synchroniser bit positions
    localparam int S_EXT = 0;
    localparam int S_POR = 1;
    localparam int S_DROP = 2;
    localparam int S_OSC = 3;
    localparam int S_RDIS = 4;
    localparam int S_WON = 5;
    localparam int S_COMPARATOR_BANDGAP_SELECT = 6;
    localparam int S_ADC = 7;
    localparam int S_FUSE = 8;
    localparam int SYNC_W = 11;

    typedef struct packed {
        logic [SYNC_W-1:0]    s1;
        logic [SYNC_W-1:0]    s2;
        logic                 osc_prev;
        logic [STRETCH_W-1:0] stretch;
        logic                 busy;
        logic [WD_CNT_W-1:0]  wd_cnt;
        logic                 irq_flag;
        logic                 irq_en;
        logic                 chg_en;
        logic [2:0]           chg_cnt;
        logic                 rst_en;
        logic [3:0]           presc;
        logic [3:0]           cause;
        logic                 wd_pulse;
        logic                 irq;
        logic                 bandgap;
    } rsw_dev_state_t;

    rsw_dev_state_t q;
    rsw_dev_state_t d;
    logic [1:0]     hold_q;
    logic           core_reset_q;
    logic           drop_on_raw;
    logic           src_n;

    // Asynchronous assertion path; raw pins on purpose so no clock is needed
    assign drop_on_raw = (drop_level_fuses != DROP_FUSE_OFF);
    assign src_n = presetn & ~por_low
                 & (ext_reset_n | ext_pin_reset_disable_fuse)
                 & ~(drop_low & drop_on_raw);

    // Reset synchroniser: set at once, released two edges after sources end
    always_ff @(posedge pclk or negedge src_n) begin
        if (!src_n) begin
            hold_q       <= 2'h3;
            core_reset_q <= 1'b1;
        end else begin
            hold_q       <= {hold_q[0], 1'b0};
            core_reset_q <= hold_q[1] | q.busy | q.wd_pulse;
        end
    end

    // Next state of the watchdog and the start-up stretch
    always_comb begin
        logic                tick;
        logic                expire;
        logic                won;
        logic [WD_CNT_W-1:0] lim;
        logic [3:0]          code;
        logic [7:0]          wd;
        d      = q;
        wd     = link.wr_data;
        won    = q.s2[S_WON];
        tick   = q.s2[S_OSC] & ~q.osc_prev;
        expire = 1'b0;
        code   = (q.presc > WD_MAX_CODE) ? WD_MAX_CODE : q.presc;
        lim    = {WD_CNT_W{1'b1}} >> (WD_MAX_CODE - code);
        d.s1       = {drop_level_fuses, adc_enable, comparator_bandgap_select,
                      watchdog_always_on_fuse, ext_pin_reset_disable_fuse,
                      wd_osc, drop_low, por_low, ext_reset_n};
        d.s2       = q.s1;
        d.osc_prev = q.s2[S_OSC];
        d.wd_pulse = 1'b0;

        // Counter runs whatever the sleep state; nothing here sees sleep
        if (link.wd_restart) begin
            d.wd_cnt = '0;
        end else if (tick && (q.rst_en || q.irq_en)) begin
            if (q.wd_cnt == lim) begin
                d.wd_cnt = '0;
                expire   = 1'b1;
            end else begin
                d.wd_cnt = q.wd_cnt + 1'b1;
            end
        end

        // Change window closes by itself
        if (q.chg_en) begin
            if (q.chg_cnt == 3'h1) begin
                d.chg_en = 1'b0;
            end
            d.chg_cnt = q.chg_cnt - 1'b1;
        end

        // Clears from the core first, so a hardware set below wins
        if (link.irq_ack) begin
            d.irq_flag = 1'b0;
            if (q.rst_en) begin
                d.irq_en = 1'b0;
            end
        end
        if (link.cause_wr) begin
            d.cause = q.cause & wd[3:0];
        end
        if (link.ctl_wr) begin
            if (wd[CTL_IRQ_FLAG]) begin
                d.irq_flag = 1'b0;
            end
            d.irq_en = wd[CTL_IRQ_EN];
            if (wd[CTL_CHG_EN] && wd[CTL_RST_EN]) begin
                d.chg_en  = 1'b1;
                d.chg_cnt = WIN_CYCLES;
                d.rst_en  = 1'b1;
            end else if (q.chg_en) begin
                d.chg_en = 1'b0;
                d.rst_en = wd[CTL_RST_EN];
                d.presc  = {wd[CTL_PRESC3], wd[2:0]};
            end else begin
                d.rst_en = q.rst_en | wd[CTL_RST_EN];
            end
        end

        // Expiry action follows the enable pair
        if (expire) begin
            if (q.irq_en && !won) begin
                if (q.irq_flag && q.rst_en) begin
                    d.wd_pulse = 1'b1;
                end else begin
                    d.irq_flag = 1'b1;
                end
            end else if (q.rst_en || won) begin
                d.wd_pulse = 1'b1;
            end
        end
        if (q.wd_pulse) begin
            d.cause[CAUSE_WD] = 1'b1;
        end

        // Start-up stretch restarts on any source or at the end of the pulse
        if (hold_q[1] || q.wd_pulse) begin
            d.busy    = 1'b1;
            d.stretch = '0;
        end else if (q.busy) begin
            if (q.stretch == STRETCH_W'(STARTUP_CNT - 1)) begin
                d.busy = 1'b0;
            end
            d.stretch = q.stretch + 1'b1;
        end

        // Sources seen by the clock record the cause; power-on wipes the rest
        if (q.s2[S_EXT] == 1'b0 && !q.s2[S_RDIS]) begin
            d.cause[CAUSE_EXT] = 1'b1;
        end
        if (q.s2[S_DROP] && (q.s2[S_FUSE+2:S_FUSE] != DROP_FUSE_OFF)) begin
            d.cause[CAUSE_DROP] = 1'b1;
        end
        if (q.s2[S_POR]) begin
            d.cause = 4'h1 << CAUSE_POR;
        end

        // Control register returns to reset value while a source holds or the pulse runs, except reset enable under the watchdog flag or always-on fuse
        if (hold_q[1] || q.wd_pulse) begin
            d.irq_flag = 1'b0;
            d.irq_en   = 1'b0;
            d.chg_en   = 1'b0;
            d.presc    = '0;
            d.wd_cnt   = '0;
            d.rst_en   = 1'b0;
        end
        if (d.cause[CAUSE_WD]) begin
            d.rst_en = 1'b1;
        end
        if (won) begin
            d.rst_en = 1'b1;
            d.irq_en = 1'b0;
        end

        // Request is a level so it can wake a stopped core
        d.irq     = d.irq_flag & d.irq_en;
        d.bandgap = (q.s2[S_FUSE+2:S_FUSE] != DROP_FUSE_OFF)
                  | q.s2[S_COMPARATOR_BANDGAP_SELECT] | q.s2[S_ADC];
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q          <= '0;
            // Idle pin levels: reset pin high, drop fuses off, other levels low
            q.s1       <= 11'h701;
            q.s2       <= 11'h701;
            q.osc_prev <= 1'b0;
            q.busy     <= 1'b1;
            q.presc    <= CTL_RESET[3:0];
            q.cause    <= CAUSE_RESET;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from flops
    assign core_reset      = core_reset_q;
    assign bandgap_on      = q.bandgap;
    assign link.core_reset = core_reset_q;
    assign link.wd_irq     = q.irq;
    assign link.cause_rd   = q.cause;
    assign link.ctl_rd     = {q.irq_flag, q.irq_en, q.presc[3], q.chg_en,
                              q.rst_en, q.presc[2:0]};
endmodule

/* File: verilog/rsw_link_if.sv */
// Purpose: Link between the core end and the reset/watchdog device end
// Assumes: Both ends run on the same pclk
// Notes:   Strobes are one-cycle pulses; read values are levels
interface rsw_link_if;
    logic       ctl_wr;      // Write control byte
    logic       cause_wr;    // Write cause byte (zeros clear)
    logic [7:0] wr_data;     // Data for either write
    logic       wd_restart;  // Watchdog restart
    logic       irq_ack;     // Interrupt vector executed
    logic [7:0] ctl_rd;      // Control byte as held
    logic [3:0] cause_rd;    // Reset cause flags
    logic       wd_irq;      // Watchdog interrupt request
    logic       core_reset;  // Internal reset to the core

    modport dev  (input  ctl_wr, cause_wr, wr_data, wd_restart, irq_ack,
                  output ctl_rd, cause_rd, wd_irq, core_reset);
    modport core (output ctl_wr, cause_wr, wr_data, wd_restart, irq_ack,
                  input  ctl_rd, cause_rd, wd_irq, core_reset);
endinterface

/* File: verilog/rsw_pkg.sv */
// Purpose: Shared constants for the reset merger and watchdog ends
// Assumes: 50 MHz pclk, watchdog oscillator sampled as a plain input
// Notes:   Control byte layout is shared by the core end and the device end
package rsw_pkg;
    // System clock
    localparam int          CLK_MHZ           = 50;
    // Start-up stretch after all reset sources go quiet
    localparam int          STARTUP_DELAY_US  = 4100;
    localparam int          STARTUP_CYCLES    = STARTUP_DELAY_US * CLK_MHZ;
    localparam int          STRETCH_W         = 24;
    // Watchdog oscillator and time-out range
    localparam int          WD_OSC_KHZ        = 128;
    localparam int          WD_CNT_W          = 20;
    localparam logic [3:0]  WD_MAX_CODE       = 4'h9;
    // Change window length in pclk cycles
    localparam logic [2:0]  WIN_CYCLES        = 3'h4;
    // Control byte fields
    localparam int          CTL_IRQ_FLAG      = 7;
    localparam int          CTL_IRQ_EN        = 6;
    localparam int          CTL_PRESC3        = 5;
    localparam int          CTL_CHG_EN        = 4;
    localparam int          CTL_RST_EN        = 3;
    localparam logic [7:0]  CTL_RESET         = 8'h00;
    // Reset cause byte fields
    localparam int          CAUSE_POR         = 0;
    localparam int          CAUSE_EXT         = 1;
    localparam int          CAUSE_DROP        = 2;
    localparam int          CAUSE_WD          = 3;
    localparam logic [3:0]  CAUSE_RESET       = 4'h0;
    // Drop level fuses all unprogrammed means detector off
    localparam logic [2:0]  DROP_FUSE_OFF     = 3'h7;
    // APB map of the core end
    localparam int          APB_AW            = 8;
    localparam logic [7:0]  OFS_CONTROL       = 8'h00;
    localparam logic [7:0]  OFS_CAUSE         = 8'h04;
    localparam logic [7:0]  OFS_COMMAND       = 8'h08;
    localparam logic [7:0]  OFS_STATUS        = 8'h0C;
    localparam int          CMD_RESTART       = 0;
    localparam int          CMD_IRQ_ACK       = 1;
    localparam int          CMD_OPEN_CHANGE   = 2;
    localparam int          STAT_IRQ          = 0;
    localparam int          STAT_CORE_RESET   = 1;
endpackage
